/* File: design/rcs_pkg.sv */
package rcs_pkg;

  // Register indices; byte address on the bus is four times the index
  localparam logic [7:0]  IDX_DIV_RATE    = 8'h0a;
  localparam logic [7:0]  IDX_CTRL        = 8'h0b;
  localparam logic [7:0]  IDX_FLAG        = 8'h0c;
  localparam logic [7:0]  IDX_VALID       = 8'h0d;
  localparam logic [7:0]  IDX_GP_FIRST    = 8'h0e;
  localparam logic [7:0]  IDX_GP_LAST     = 8'hff;

  // Divider and rate register fields
  localparam int          DRR_UIP_BIT     = 7;
  localparam int          DRR_DIV_LSB     = 4;
  localparam int          DRR_RATE_LSB    = 0;
  localparam logic [2:0]  DIV_SEL_RST     = 3'h0;
  localparam logic [3:0]  RATE_SEL_RST    = 4'h0;

  // Control register fields
  localparam int          CTRL_SET_BIT    = 7;
  localparam int          CTRL_PIE_BIT    = 6;
  localparam int          CTRL_AIE_BIT    = 5;
  localparam int          CTRL_UIE_BIT    = 4;
  localparam int          CTRL_DM_BIT     = 2;
  localparam int          CTRL_HR24_BIT   = 1;

  // Flag register fields
  localparam int          FLAG_IRQ_BIT    = 7;
  localparam int          FLAG_PF_BIT     = 6;
  localparam int          FLAG_AF_BIT     = 5;
  localparam int          FLAG_UF_BIT     = 4;

  // Validity register field
  localparam int          VALID_BIT       = 7;

  // Divider select codes
  localparam logic [2:0]  DIV_NORMAL      = 3'h2;
  localparam logic [1:0]  DIV_STOP_TOP    = 2'h0;
  localparam logic [1:0]  DIV_HOLD_TOP    = 2'h3;

  // Timing, counted in oscillator ticks
  localparam int          OSC_HZ          = 32768;
  localparam int          UIP_LEAD_US     = 244;
  localparam int          UPD_CYCLE_US    = 1948;
  localparam int          LEAD_TICKS      = (UIP_LEAD_US * OSC_HZ + 999999) / 1000000;
  localparam int          UPD_TICKS       = (UPD_CYCLE_US * OSC_HZ + 999999) / 1000000;
  localparam logic [14:0] HALF_SEC_TICKS  = 15'(OSC_HZ / 2);
  localparam logic [14:0] UIP_START_CNT   = 15'(OSC_HZ / 2 - LEAD_TICKS);
  localparam logic [6:0]  LEAD_LAST       = 7'(LEAD_TICKS - 1);
  localparam logic [6:0]  UPD_LAST        = 7'(UPD_TICKS - 1);

  // Bus answers
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef struct packed {
    logic set;
    logic periodic_irq_enable;
    logic alarm_irq_enable;
    logic update_irq_enable;
    logic dm;
    logic hr24;
  } rcs_ctrl_t;

  typedef struct packed {
    logic pf;
    logic af;
    logic uf;
  } rcs_flags_t;

  typedef struct packed {
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } rcs_time_t;

  typedef enum logic [2:0] {
    UPD_IDLE = 3'b001,
    UPD_LEAD = 3'b010,
    UPD_BUSY = 3'b100
  } rcs_upd_state_t;

endpackage

/* File: design/rcs_rtc_ctrl.sv */
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
// Operation
// - Divider select: 00x stops, 010 normal, 011/10x test, 11x holds chain reset.
// - After divider reset release, first update starts half a second later.
// - Divider and rate selects are read/write and survive bus reset.
// - Rate select picks one of thirteen taps through codes 1-15; zero disables periodic events.
// - Codes 1,2 give 3.90625/7.8125 ms; 3 gives 122.070 us, doubling to 500 ms.
// - Hold bit aborts any update and blocks new ones; clear means once-per-second.
// - Hold bit changes only by software write.
// - Periodic flag reaches interrupt only when enabled; flag sets anyway; bus reset clears enable.
// - Alarm when all three time bytes match; 11xxxxxx matches anything; gated by enable.
// - Update interrupt enable gates update flag; cleared by bus reset and hold rising.
// - Binary format bit: 1 binary, 0 BCD; only software changes it.
// - Hour format bit: 1 for 24-hour, 0 for 12-hour; software only.
// - Daylight saving bit and bit 3 of control read zero.
// - Pending bit set when any flag and its enable are set; interrupt low exactly then.
// - Reading the flag register or bus reset clears all flags.
// - Periodic flag sets on the selected tap edge regardless of enable.
// - Alarm flag sets at the end of an update cycle when current time matches alarm time.
// - Update-done flag sets at the end of every update cycle.
// - Flag register bits 3..0 read zero and ignore writes.
// - Contents-valid bit reads 1 when valid, 0 after low battery; reading sets it.
// - Validity register bits 6..0 read zero and ignore writes.
// - General-purpose bytes always accessible and retained on battery.
// - Writing hold 1 blocks updates and then clears update-in-progress.
// - Updates run once per second only when hold is clear and divider not held.
// - Flags stable during a read; events during the read are kept.
module rcs_rtc_ctrl
  import rcs_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        osc_in,
  input  wire logic        bus_reset,
  input  wire logic        battery_low,
  input  wire rcs_time_t   cur_time,
  input  wire rcs_time_t   alarm_time,
  output logic             irq_out_n,
  output logic             update_tick,
  output logic             binary_format_select,
  output logic             hour_format_24
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [1:0] osc_sync_reg;
  logic       osc_prev_reg;
  logic [1:0] brst_sync_reg;
  logic [1:0] batt_sync_reg;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      osc_sync_reg  <= 2'h0;
      osc_prev_reg  <= 1'b0;
      brst_sync_reg <= 2'h0;
      batt_sync_reg <= 2'h0;
    end else begin
      osc_sync_reg  <= {osc_sync_reg[0], osc_in};
      osc_prev_reg  <= osc_sync_reg[1];
      brst_sync_reg <= {brst_sync_reg[0], bus_reset};
      batt_sync_reg <= {batt_sync_reg[0], battery_low};
    end
  end

  wire osc_tick = osc_sync_reg[1] & ~osc_prev_reg;
  wire brst     = brst_sync_reg[1];
  wire batt_low = batt_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [2:0]     div_sel_reg;
  logic [3:0]     rate_sel_reg;
  rcs_ctrl_t      ctrl_reg;
  rcs_flags_t     flags_reg;
  logic           valid_reg;
  logic           irq_n_reg;
  logic [7:0]     gp_mem [IDX_GP_FIRST:IDX_GP_LAST];
  logic [14:0]    div_cnt_reg;
  rcs_upd_state_t upd_state_reg;
  logic [6:0]     upd_cnt_reg;
  logic           upd_tick_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: one write and one read in flight
  logic       awready_reg;
  logic       wready_reg;
  logic       bvalid_reg;
  logic [1:0] bresp_reg;
  logic       arready_reg;
  logic       rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic [11:0] wr_addr_reg;
  logic [7:0]  wr_data_reg;
  logic        wr_strb_reg;

  wire aw_hs   = s_axi_awvalid & awready_reg;
  wire w_hs    = s_axi_wvalid & wready_reg;
  wire wr_fire = ~awready_reg & ~wready_reg & ~bvalid_reg;
  wire ar_hs   = s_axi_arvalid & arready_reg;

  // Upper address bits must be zero; the index sits in bits 9..2
  wire [7:0] wr_idx    = wr_addr_reg[9:2];
  wire       wr_in     = (wr_addr_reg[11:10] == 2'h0) && (wr_idx >= IDX_DIV_RATE);
  wire       wr_en     = wr_fire & wr_in & wr_strb_reg;
  wire       wr_drr    = wr_en && (wr_idx == IDX_DIV_RATE);
  wire       wr_ctrl   = wr_en && (wr_idx == IDX_CTRL);
  wire       wr_gp     = wr_en && (wr_idx >= IDX_GP_FIRST);

  wire [7:0] rd_idx    = s_axi_araddr[9:2];
  wire       rd_in     = (s_axi_araddr[11:10] == 2'h0) && (rd_idx >= IDX_DIV_RATE);
  wire       rd_flag   = ar_hs && rd_in && (rd_idx == IDX_FLAG);
  wire       rd_valid  = ar_hs && rd_in && (rd_idx == IDX_VALID);

  ////////////////////////////////////////////////////////////////////////////
  // Divider chain and mode decode
  wire div_stop = (div_sel_reg[2:1] == DIV_STOP_TOP);
  wire div_hold = (div_sel_reg[2:1] == DIV_HOLD_TOP);
  // Test codes run the chain like normal mode
  wire div_run  = ~div_stop & ~div_hold;

  wire [14:0] div_cnt_inc = div_cnt_reg + 15'h1;

  // Codes 1 and 2 reuse the 256 Hz and 128 Hz taps
  wire [3:0]  tap_k    = (rate_sel_reg < 4'h3) ? 4'(rate_sel_reg + 4'h6)
                                               : 4'(rate_sel_reg - 4'h1);
  wire [15:0] tap_full = (16'h1 << tap_k) - 16'h1;
  wire [14:0] tap_mask = tap_full[14:0];
  wire        pf_set   = osc_tick & div_run & (rate_sel_reg != 4'h0)
                         & ((div_cnt_inc & tap_mask) == 15'h0);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_cnt_reg <= 15'h0;
    end else if (div_hold) begin
      div_cnt_reg <= 15'h0;
    end else if (div_run && osc_tick) begin
      div_cnt_reg <= div_cnt_inc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Update cycle: lead-in with progress bit high, then the update itself
  function automatic logic byte_match(input logic [7:0] a, input logic [7:0] t);
    byte_match = (a[7:6] == 2'h3) || (a == t);
  endfunction

  wire alarm_hit = byte_match(alarm_time.sec, cur_time.sec)
                 & byte_match(alarm_time.min, cur_time.min)
                 & byte_match(alarm_time.hour, cur_time.hour);

  // Counter restarts at zero on release, so the first start lands 8 ticks before 0.5 s and the update at 0.5 s
  wire upd_allow = ~ctrl_reg.set & div_run;
  wire upd_start = upd_allow & osc_tick & (div_cnt_inc == UIP_START_CNT);
  wire upd_last  = osc_tick & (upd_cnt_reg == UPD_LAST);
  wire upd_end   = upd_allow & (upd_state_reg == UPD_BUSY) & upd_last;
  wire af_set    = upd_end & alarm_hit;
  wire update_in_progress       = (upd_state_reg != UPD_IDLE);

  rcs_upd_state_t upd_state_next;
  logic [6:0]     upd_cnt_next;
  logic           upd_tick_next;

  always_comb begin
    upd_state_next = upd_state_reg;
    upd_cnt_next   = upd_cnt_reg;
    upd_tick_next  = 1'b0;
    case (upd_state_reg)
      UPD_IDLE: begin
        if (upd_start) begin
          upd_state_next = UPD_LEAD;
          upd_cnt_next   = 7'h0;
        end
      end
      UPD_LEAD: begin
        if (osc_tick) begin
          upd_cnt_next = 7'(upd_cnt_reg + 7'h1);
        end
        if (osc_tick && (upd_cnt_reg == LEAD_LAST)) begin
          upd_state_next = UPD_BUSY;
          upd_cnt_next   = 7'h0;
          upd_tick_next  = 1'b1;
        end
      end
      UPD_BUSY: begin
        if (osc_tick) begin
          upd_cnt_next = 7'(upd_cnt_reg + 7'h1);
        end
        if (upd_last) begin
          upd_state_next = UPD_IDLE;
        end
      end
      default: begin
        upd_state_next = UPD_IDLE;
      end
    endcase
    // Hold or a stopped chain aborts at once and drops the progress bit
    if (!upd_allow) begin
      upd_state_next = UPD_IDLE;
      upd_tick_next  = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      upd_state_reg <= UPD_IDLE;
      upd_cnt_reg   <= 7'h0;
      upd_tick_reg  <= 1'b0;
    end else begin
      upd_state_reg <= upd_state_next;
      upd_cnt_reg   <= upd_cnt_next;
      upd_tick_reg  <= upd_tick_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control, flags and interrupt
  wire set_rise = wr_ctrl & wr_data_reg[CTRL_SET_BIT] & ~ctrl_reg.set;

  rcs_ctrl_t  ctrl_next;
  rcs_flags_t flags_next;
  rcs_flags_t flags_clr;
  rcs_flags_t flags_set;

  // Only bits seen by the read are cleared; a set in that cycle wins
  assign flags_clr = rd_flag ? flags_reg : 3'h0;
  assign flags_set = '{pf: pf_set, af: af_set, uf: upd_end};
  assign flags_next = brst ? 3'h0
                    : ((flags_reg & ~flags_clr) | flags_set);

  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next.set  = wr_data_reg[CTRL_SET_BIT];
      ctrl_next.periodic_irq_enable  = wr_data_reg[CTRL_PIE_BIT];
      ctrl_next.alarm_irq_enable  = wr_data_reg[CTRL_AIE_BIT];
      ctrl_next.update_irq_enable  = wr_data_reg[CTRL_UIE_BIT];
      ctrl_next.dm   = wr_data_reg[CTRL_DM_BIT];
      ctrl_next.hr24 = wr_data_reg[CTRL_HR24_BIT];
    end
    if (set_rise) begin
      ctrl_next.update_irq_enable = 1'b0;
    end
    if (brst) begin
      ctrl_next.periodic_irq_enable = 1'b0;
      ctrl_next.alarm_irq_enable = 1'b0;
      ctrl_next.update_irq_enable = 1'b0;
    end
  end

  wire irq_pend_now  = |(flags_reg & {ctrl_reg.periodic_irq_enable, ctrl_reg.alarm_irq_enable, ctrl_reg.update_irq_enable});
  wire irq_pend_next = |(flags_next & {ctrl_next.periodic_irq_enable, ctrl_next.alarm_irq_enable, ctrl_next.update_irq_enable});

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_sel_reg  <= DIV_SEL_RST;
      rate_sel_reg <= RATE_SEL_RST;
      ctrl_reg     <= '0;
      flags_reg    <= '0;
      valid_reg    <= 1'b0;
      irq_n_reg    <= 1'b1;
    end else begin
      // Bus reset does not touch the selects
      if (wr_drr) begin
        div_sel_reg  <= wr_data_reg[DRR_DIV_LSB +: 3];
        rate_sel_reg <= wr_data_reg[DRR_RATE_LSB +: 4];
      end
      ctrl_reg  <= ctrl_next;
      flags_reg <= flags_next;
      // Output tracks the pending bit of the register state it follows
      irq_n_reg <= ~irq_pend_next;
      if (rd_valid) begin
        valid_reg <= 1'b1;
      end else if (batt_low) begin
        valid_reg <= 1'b0;
      end
    end
  end

  // Battery-backed storage: no reset, so contents outlive a system reset
  always_ff @(posedge core_clk) begin
    if (wr_gp) begin
      gp_mem[wr_idx] <= wr_data_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data
  wire [7:0] rd_drr   = {update_in_progress, div_sel_reg, rate_sel_reg};
  wire [7:0] rd_ctrl  = {ctrl_reg.set, ctrl_reg.periodic_irq_enable, ctrl_reg.alarm_irq_enable, ctrl_reg.update_irq_enable,
                         1'b0, ctrl_reg.dm, ctrl_reg.hr24, 1'b0};
  wire [7:0] rd_flags = {irq_pend_now, flags_reg, 4'h0};
  wire [7:0] rd_vld   = {valid_reg, 7'h0};
  wire [7:0] rd_byte  = !rd_in                 ? 8'h00
                      : (rd_idx == IDX_DIV_RATE) ? rd_drr
                      : (rd_idx == IDX_CTRL)     ? rd_ctrl
                      : (rd_idx == IDX_FLAG)     ? rd_flags
                      : (rd_idx == IDX_VALID)    ? rd_vld
                      : gp_mem[rd_idx];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      wr_addr_reg <= 12'h000;
      wr_data_reg <= 8'h00;
      wr_strb_reg <= 1'b0;
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= RESP_OKAY;
      rdata_reg   <= 32'h0000_0000;
    end else begin
      if (aw_hs) begin
        awready_reg <= 1'b0;
        wr_addr_reg <= s_axi_awaddr;
      end
      if (w_hs) begin
        wready_reg  <= 1'b0;
        wr_data_reg <= s_axi_wdata[7:0];
        wr_strb_reg <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_in ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_reg && s_axi_bready) begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
      if (ar_hs) begin
        arready_reg <= 1'b0;
        rvalid_reg  <= 1'b1;
        rdata_reg   <= {24'h000000, rd_byte};
        rresp_reg   <= rd_in ? RESP_OKAY : RESP_SLVERR;
      end
      if (rvalid_reg && s_axi_rready) begin
        rvalid_reg  <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  assign s_axi_awready        = awready_reg;
  assign s_axi_wready         = wready_reg;
  assign s_axi_bvalid         = bvalid_reg;
  assign s_axi_bresp          = bresp_reg;
  assign s_axi_arready        = arready_reg;
  assign s_axi_rvalid         = rvalid_reg;
  assign s_axi_rresp          = rresp_reg;
  assign s_axi_rdata          = rdata_reg;
  assign irq_out_n            = irq_n_reg;
  assign update_tick          = upd_tick_reg;
  assign binary_format_select = ctrl_reg.dm;
  assign hour_format_24       = ctrl_reg.hr24;

endmodule

/* File: dv/rcs_rtc_ctrl_chk.sv */
`timescale 1ns/1ps
module rcs_rtc_ctrl_chk
  import rcs_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        bus_reset,
  input wire logic        irq_out_n,
  input wire logic        update_tick,
  input wire logic        binary_format_select,
  input wire logic        hour_format_24
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  //////////////////////////////////////////////////////////////////////////////
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer off");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_unmapped_read: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr[9:2] < IDX_DIV_RATE
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read answered");
  a_format_by_write: assert property (
    $changed(binary_format_select) || $changed(hour_format_24) |-> $rose(s_axi_bvalid))
    else $error("format bit moved without write");
  a_bus_reset_irq: assert property (bus_reset [*6] |-> irq_out_n)
    else $error("interrupt stays under bus reset");
  a_tick_pulse: assert property (update_tick |=> !update_tick)
    else $error("update tick longer than a cycle");
  c_irq: cover property ($fell(irq_out_n));
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
  c_bus_reset: cover property (bus_reset [*6]);
endmodule

bind rcs_rtc_ctrl rcs_rtc_ctrl_chk rcs_rtc_ctrl_chk_inst (
  .core_clk(core_clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .bus_reset(bus_reset), .irq_out_n(irq_out_n), .update_tick(update_tick),
  .binary_format_select(binary_format_select), .hour_format_24(hour_format_24));

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import rcs_pkg::*;
  logic        core_clk, rst, osc_in, bus_reset, battery_low;
  logic [11:0] awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid, irq_out_n, bfs, hf24;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, rd;
  logic [1:0]  rs;
  logic [2:0]  osc_cnt = 3'h0;
  logic        fast_osc = 1'b0, utick;
  rcs_time_t   cur_t = 24'h010203, alm_t = 24'h000000;
  int          mismatches, n_compared;
  time         t0;
  rcs_rtc_ctrl rcs_rtc_ctrl_inst (.core_clk(core_clk), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .osc_in(osc_in), .bus_reset(bus_reset), .battery_low(battery_low),
    .cur_time(cur_t), .alarm_time(alm_t), .irq_out_n(irq_out_n), .update_tick(utick),
    .binary_format_select(bfs), .hour_format_24(hf24));
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Oscillator at eight core cycles a tick keeps every period an exact cycle count
  // Fast mode ticks every two cycles so that half a second fits in the run
  always @(posedge core_clk) begin
    osc_cnt <= osc_cnt + 3'h1;
    osc_in  <= fast_osc ? ~osc_in : osc_cnt[2];
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] st);
    int n;
    @(posedge core_clk);
    awaddr <= {2'b00, idx, 2'b00}; wdata <= {24'h0, d}; wstrb <= st;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
    end
    rs = bresp;
    bready <= 1'b0;
    if (n == 50) mismatches++;
  endtask
  task automatic axi_rd(input logic [7:0] idx);
    int n;
    @(posedge core_clk);
    araddr <= {2'b00, idx, 2'b00}; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
    end
    rd = rdata; rs = rresp;
    rready <= 1'b0;
    if (n == 50) mismatches++;
  endtask
  task automatic wait_irq(input int lim);
    int n;
    for (n = 0; n < lim && irq_out_n !== 1'b0; n++) @(posedge core_clk);
    if (n == lim) mismatches++;
    t0 = $time;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    axi_rd(IDX_CTRL); check(rd, 32'h0); check({30'h0, rs}, {30'h0, RESP_OKAY});
    axi_wr(IDX_DIV_RATE, 8'hff, 4'hf); axi_rd(IDX_DIV_RATE); check(rd, 32'h7f);
    axi_wr(IDX_CTRL, 8'h10, 4'hf); axi_rd(IDX_CTRL); check(rd, 32'h10);
    axi_wr(IDX_CTRL, 8'hff, 4'hf); axi_rd(IDX_CTRL); check(rd, 32'he6);
    check({30'h0, bfs, hf24}, 32'h3);
    axi_wr(IDX_CTRL, 8'h00, 4'h0); axi_rd(IDX_CTRL); check(rd, 32'he6);
    axi_wr(IDX_FLAG, 8'hff, 4'hf); axi_rd(IDX_FLAG); check(rd, 32'h0);
    axi_wr(8'h05, 8'h55, 4'hf); check({30'h0, rs}, {30'h0, RESP_SLVERR});
    axi_rd(8'h05); check({rd[29:0], rs}, {30'h0, RESP_SLVERR});
    axi_wr(IDX_GP_FIRST, 8'ha5, 4'hf); axi_wr(IDX_GP_LAST, 8'h5a, 4'hf);
    axi_rd(IDX_GP_FIRST); check(rd, 32'ha5);
    axi_rd(IDX_GP_LAST); check(rd, 32'h5a);
  endtask
  task automatic t_valid();
    axi_wr(IDX_VALID, 8'hff, 4'hf); axi_rd(IDX_VALID); check(rd, 32'h0);
    axi_rd(IDX_VALID); check(rd, 32'h80);
    battery_low <= 1'b1;
    repeat (6) @(posedge core_clk);
    battery_low <= 1'b0;
    axi_rd(IDX_VALID); check(rd, 32'h0);
  endtask
  task automatic t_rates();
    int  code;
    time t1;
    axi_wr(IDX_CTRL, 8'h40, 4'hf);
    for (code = 1; code < 10; code++) begin
      axi_wr(IDX_DIV_RATE, 8'h20 | 8'(code), 4'hf);
      axi_rd(IDX_FLAG); @(posedge core_clk);
      wait_irq(5000);
      t1 = t0;
      axi_rd(IDX_FLAG); check(rd, 32'hc0); @(posedge core_clk);
      wait_irq(5000);
      check(32'(t0 - t1), 32'(80 << (code < 3 ? code + 6 : code - 1)));
    end
  endtask
  task automatic t_gating();
    axi_wr(IDX_DIV_RATE, 8'h23, 4'hf); axi_wr(IDX_CTRL, 8'h00, 4'hf);
    axi_rd(IDX_FLAG);
    repeat (40) @(posedge core_clk);
    check({31'h0, irq_out_n}, 32'h1);
    axi_rd(IDX_FLAG); check(rd, 32'h40);
    axi_wr(IDX_DIV_RATE, 8'h20, 4'hf); axi_rd(IDX_FLAG);
    repeat (100) @(posedge core_clk);
    axi_rd(IDX_FLAG); check(rd, 32'h0);
  endtask
  task automatic t_bus_reset();
    axi_wr(IDX_DIV_RATE, 8'h23, 4'hf); axi_wr(IDX_CTRL, 8'h76, 4'hf);
    wait_irq(200);
    bus_reset <= 1'b1;
    repeat (8) @(posedge core_clk);
    check({31'h0, irq_out_n}, 32'h1);
    bus_reset <= 1'b0;
    repeat (4) @(posedge core_clk);
    axi_rd(IDX_CTRL); check(rd, 32'h06);
    axi_rd(IDX_DIV_RATE); check(rd, 32'h23);
  endtask
  task automatic t_update();
    int  n;
    time dt;
    alm_t <= 24'hc0c0c0; fast_osc <= 1'b1;
    axi_wr(IDX_DIV_RATE, 8'h60, 4'hf); axi_wr(IDX_CTRL, 8'h10, 4'hf); axi_rd(IDX_FLAG);
    axi_wr(IDX_DIV_RATE, 8'h20, 4'hf); dt = $time;
    for (n = 0; n < 40000 && utick !== 1'b1; n++) @(posedge core_clk);
    if (n == 40000) mismatches++;
    dt = $time - dt;
    // Half a second is 16384 ticks of 20 ns; the window allows for synchroniser phase
    check({31'h0, dt > 327600 && dt < 327760}, 32'h1);
    axi_rd(IDX_DIV_RATE); check(rd, 32'ha0);
    wait_irq(400);
    axi_rd(IDX_FLAG); check(rd, 32'hb0);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1; bus_reset = 1'b0; battery_low = 1'b0;
    awaddr = 12'h0; araddr = 12'h0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; wdata = 32'h0; wstrb = 4'h0;
    mismatches = 0; n_compared = 0;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    t_regs();
    t_valid();
    t_rates();
    t_gating();
    t_bus_reset();
    t_update();
    print_verdict();
  end
  // Rate pairs plus the half-second update wait stay well inside this span
  initial begin
    #900us;
    mismatches++;
    print_verdict();
  end
endmodule
